// ---- logic/tocc_channel.v ----
// one output compare timer channel with pin filters
// Overview of operation
// [RULE1] a pin level is accepted after three identical samples
// [RULE2] filter use and sampling clock are chosen per channel; the code sets filter use per pin (bits 3:0), sampling clock per channel
// [RULE3] counter is compared with every match value continuously
// [RULE4] a match drives the configured level onto its pin
// [RULE5] each pin and match register pair selects compare or other mode
// [RULE6] count source is f1, f2, f4, f8, f32 or fast oscillator
// [RULE7] counter may step on the chosen edge of the external input
// [RULE8] clear select zero gives a free running 65536 count period
// [RULE9] clear select 01b or 10b clears on match, period n+1
// [RULE10] writing one to the run bit starts counting
// [RULE11] in stop mode one, writing zero stops, pins hold level
// [RULE12] in stop mode zero, period match stops counter, pin holds
// [RULE13] unfiltered inputs must be held three operation clocks outside
// [RULE14] request raised on any match and on overflow
// [RULE15] match level is low, high or toggle; initial level programmable
// [RULE16] 16 bit counter wraps to zero and flags overflow
// [RULE17] each match sets a sticky status flag software clears
`timescale 1ns/1ps
`include "tocc_defines.vh"
module tocc_channel (
  mclk,
  sys_rst,
  fast_oscillator_clock,
  external_count_input,
  pin_in,
  count_run_wr,
  count_run_bit,
  stop_mode_select,
  source_select,
  edge_select,
  counter_clear_select,
  compare_enable,
  match_action,
  initial_level,
  filter_config_reg,
  match_value_reg0,
  match_value_reg1,
  match_value_reg2,
  match_value_reg3,
  match_clear,
  ovf_clear,
  channel_counter,
  counter_running,
  compare_pin,
  compare_pin_oe,
  filtered_in,
  match_flag,
  ovf_flag,
  irq_req
);
  input wire mclk;
  input wire sys_rst;
  input wire fast_oscillator_clock;
  input wire external_count_input;
  input wire [3:0] pin_in;
  input wire count_run_wr;
  input wire count_run_bit;
  input wire stop_mode_select;
  input wire [2:0] source_select;
  input wire [1:0] edge_select;
  input wire [2:0] counter_clear_select;
  input wire [3:0] compare_enable;
  input wire [7:0] match_action;
  input wire [3:0] initial_level;
  // bits 3:0 per pin filter enable, bits 5:4 sampling clock choice
  input wire [5:0] filter_config_reg;
  input wire [15:0] match_value_reg0;
  input wire [15:0] match_value_reg1;
  input wire [15:0] match_value_reg2;
  input wire [15:0] match_value_reg3;
  input wire [3:0] match_clear;
  input wire ovf_clear;
  output reg [15:0] channel_counter;
  output reg counter_running;
  output reg [3:0] compare_pin;
  output reg [3:0] compare_pin_oe;
  output wire [3:0] filtered_in;
  output reg [3:0] match_flag;
  output reg ovf_flag;
  output reg irq_req;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function pin_action;
    input [1:0] act;
    input cur;
    begin
      case (act)
        `TOCC_ACT_LOW: pin_action = 1'b0;
        `TOCC_ACT_HIGH: pin_action = 1'b1;
        `TOCC_ACT_TOGGLE: pin_action = ~cur;
        default: pin_action = cur;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers and filters
  // ----------------------------------------------------------------------
  wire [3:0] pin_sync;
  wire ext_sync;
  wire osc_sync;
  reg [4:0] presc_r;
  reg osc_d_r;
  reg ext_d_r;
  wire osc_tick;
  reg filt_tick;
  assign osc_tick = osc_sync & ~osc_d_r;

  always @* begin
    case (filter_config_reg[5:4]) // [RULE2]
      2'h0: filt_tick = 1'b1;
      2'h1: filt_tick = (presc_r[2:0] == 3'h7);
      2'h2: filt_tick = (presc_r == `TOCC_PRESC_F32);
      default: filt_tick = osc_tick;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : pin_g
      tocc_sync u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(pin_in[g]),
        .dout(pin_sync[g])
      );
      tocc_filter u_filt (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(pin_sync[g]),
        .filter_enable_bit(filter_config_reg[g]),
        .sample_tick(filt_tick),
        .dout(filtered_in[g])
      );
    end
  endgenerate

  tocc_sync u_ext_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(external_count_input),
    .dout(ext_sync)
  );
  tocc_sync u_osc_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(fast_oscillator_clock),
    .dout(osc_sync)
  );

  // ----------------------------------------------------------------------
  // count source
  // ----------------------------------------------------------------------
  reg cnt_tick;
  always @* begin
    case (source_select) // [RULE6]
      `TOCC_SRC_F1: cnt_tick = 1'b1;
      `TOCC_SRC_F2: cnt_tick = (presc_r[0] == 1'b1);
      `TOCC_SRC_F4: cnt_tick = (presc_r[1:0] == 2'h3);
      `TOCC_SRC_F8: cnt_tick = (presc_r[2:0] == 3'h7);
      `TOCC_SRC_F32: cnt_tick = (presc_r == `TOCC_PRESC_F32);
      `TOCC_SRC_FOSC: cnt_tick = osc_tick;
      `TOCC_SRC_EXT: begin
        case (edge_select) // [RULE7]
          `TOCC_EDGE_RISE: cnt_tick = ext_sync & ~ext_d_r;
          `TOCC_EDGE_FALL: cnt_tick = ~ext_sync & ext_d_r;
          default: cnt_tick = ext_sync ^ ext_d_r;
        endcase
      end
      default: cnt_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // compare and clear decisions
  // ----------------------------------------------------------------------
  wire [3:0] match_hit;
  // a match counts only while the counter rests on the value for a tick
  assign match_hit[0] = (channel_counter == match_value_reg0); // [RULE3]
  assign match_hit[1] = (channel_counter == match_value_reg1); // [RULE3]
  assign match_hit[2] = (channel_counter == match_value_reg2); // [RULE3]
  assign match_hit[3] = (channel_counter == match_value_reg3); // [RULE3]
  wire step;
  wire [3:0] match_ev;
  wire ovf_ev;
  wire clr_on_match;
  wire self_stop;
  assign step = counter_running & cnt_tick;
  assign match_ev = step ? match_hit : 4'h0;
  assign ovf_ev = step & (channel_counter == `TOCC_CNT_MAX); // [RULE16]
  assign clr_on_match = ((counter_clear_select[1:0] == `TOCC_CLR_MATCH_A) & match_ev[0]) |
                        ((counter_clear_select[1:0] == `TOCC_CLR_MATCH_B) & match_ev[1]); // [RULE9]
  assign self_stop = ~stop_mode_select & match_ev[0]; // [RULE12]

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  integer k;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_r <= 5'h00;
      osc_d_r <= 1'b0;
      ext_d_r <= 1'b0;
      channel_counter <= `TOCC_CNT_RST;
      counter_running <= 1'b0;
      compare_pin <= 4'h0;
      compare_pin_oe <= 4'h0;
      match_flag <= 4'h0;
      ovf_flag <= 1'b0;
      irq_req <= 1'b0;
    end else begin
      presc_r <= presc_r + 5'h01;
      osc_d_r <= osc_sync;
      ext_d_r <= ext_sync;
      compare_pin_oe <= compare_enable; // [RULE5]
      irq_req <= (|match_ev) | ovf_ev; // [RULE14]
      if (count_run_wr && count_run_bit && !counter_running) begin
        counter_running <= 1'b1; // [RULE10]
        for (k = 0; k < 4; k = k + 1) begin
          compare_pin[k] <= initial_level[k]; // [RULE15]
        end
      end else if (count_run_wr && !count_run_bit && stop_mode_select) begin
        counter_running <= 1'b0; // [RULE11]
      end else if (self_stop) begin
        counter_running <= 1'b0; // [RULE12]
      end
      if (step) begin
        if (clr_on_match) begin
          channel_counter <= `TOCC_CNT_RST; // [RULE9]
        end else begin
          channel_counter <= channel_counter + 16'h0001; // [RULE8] [RULE16]
        end
      end
      for (k = 0; k < 4; k = k + 1) begin
        if (match_ev[k] && compare_enable[k]) begin
          compare_pin[k] <= pin_action(match_action[2*k+1 -: 2], compare_pin[k]); // [RULE4]
        end
        // set wins over software clear
        if (match_ev[k]) begin
          match_flag[k] <= 1'b1; // [RULE17]
        end else if (match_clear[k]) begin
          match_flag[k] <= 1'b0;
        end
      end
      if (ovf_ev) begin
        ovf_flag <= 1'b1; // [RULE16]
      end else if (ovf_clear) begin
        ovf_flag <= 1'b0;
      end
    end
  end
endmodule

// ---- logic/tocc_defines.vh ----
// constants for the timer output compare channel
`ifndef TOCC_DEFINES_VH
`define TOCC_DEFINES_VH
// ----------------------------------------------------------------------
// count source select codes
// ----------------------------------------------------------------------
`define TOCC_SRC_F1 3'h0
`define TOCC_SRC_F2 3'h1
`define TOCC_SRC_F4 3'h2
`define TOCC_SRC_F8 3'h3
`define TOCC_SRC_F32 3'h4
`define TOCC_SRC_EXT 3'h5
`define TOCC_SRC_FOSC 3'h6
// ----------------------------------------------------------------------
// counter clear select codes
// ----------------------------------------------------------------------
`define TOCC_CLR_FREE 3'h0
`define TOCC_CLR_MATCH_A 2'h1
`define TOCC_CLR_MATCH_B 2'h2
// ----------------------------------------------------------------------
// external edge select codes
// ----------------------------------------------------------------------
`define TOCC_EDGE_RISE 2'h0
`define TOCC_EDGE_FALL 2'h1
`define TOCC_EDGE_BOTH 2'h2
// ----------------------------------------------------------------------
// match action codes
// ----------------------------------------------------------------------
`define TOCC_ACT_NONE 2'h0
`define TOCC_ACT_LOW 2'h1
`define TOCC_ACT_HIGH 2'h2
`define TOCC_ACT_TOGGLE 2'h3
// ----------------------------------------------------------------------
// filter and counter sizes
// ----------------------------------------------------------------------
`define TOCC_FILT_SAMPLES 3
`define TOCC_CNT_MAX 16'hFFFF
`define TOCC_CNT_RST 16'h0000
`define TOCC_PRESC_F2 5'h01
`define TOCC_PRESC_F4 5'h03
`define TOCC_PRESC_F8 5'h07
`define TOCC_PRESC_F32 5'h1F
`endif

// ---- logic/tocc_sync.v ----
// two flop synchroniser for one pin level
`timescale 1ns/1ps
module tocc_sync (
  mclk,
  sys_rst,
  din,
  dout
);
  input wire mclk;
  input wire sys_rst;
  input wire din;
  output reg dout;
  reg meta_r;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule

// ---- logic/tocc_filter.v ----
// three sample digital noise filter for one pin
`timescale 1ns/1ps
`include "tocc_defines.vh"
module tocc_filter (
  mclk,
  sys_rst,
  din,
  filter_enable_bit,
  sample_tick,
  dout
);
  input wire mclk;
  input wire sys_rst;
  input wire din;
  input wire filter_enable_bit;
  input wire sample_tick;
  output reg dout;
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // ----------------------------------------------------------------------
  // sample shift and level decision
  // ----------------------------------------------------------------------
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      if (sample_tick) begin
        s1_r <= din;
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
      if (!filter_enable_bit) begin
        dout <= din; // [RULE2]
      end else if (s1_r == s2_r && s2_r == s3_r) begin
        dout <= s3_r; // [RULE1]
      end
    end
  end
endmodule

// ---- sim/tocc_chk.sv ----
// assertion checker for the output compare channel
`timescale 1ns/1ps
module tocc_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic count_run_wr,
  input wire logic count_run_bit,
  input wire logic stop_mode_select,
  input wire logic [2:0] source_select,
  input wire logic [2:0] counter_clear_select,
  input wire logic [3:0] initial_level,
  input wire logic [15:0] match_value_reg0,
  input wire logic [15:0] channel_counter,
  input wire logic counter_running,
  input wire logic [3:0] compare_pin,
  input wire logic [3:0] match_flag,
  input wire logic ovf_flag,
  input wire logic irq_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // only the f1 source ticks on every edge, so exact counts are checked there
  wire t = counter_running && source_select == 3'h0;
  wire e0 = t && channel_counter == match_value_reg0;
  wire fr = counter_clear_select[1:0] == 2'h0;
  wire go = count_run_wr && count_run_bit && !counter_running;
  a_start_run: assert property (go |=> counter_running && compare_pin == $past(initial_level))
    else $error("start failed");
  a_sw_stop: assert property (counter_running && count_run_wr && !count_run_bit &&
    stop_mode_select |=> !counter_running)
    else $error("stop failed");
  a_stop_refused: assert property (counter_running && !stop_mode_select &&
    channel_counter != match_value_reg0 |=> counter_running)
    else $error("stop not refused");
  a_self_stop: assert property (e0 && !stop_mode_select |=> !counter_running)
    else $error("no self stop");
  a_pins_hold: assert property (!counter_running && !count_run_wr |=> $stable(compare_pin))
    else $error("pin moved while stopped");
  a_count_step: assert property (t && fr |=> channel_counter == $past(channel_counter) + 16'h0001)
    else $error("count step");
  a_clear_match: assert property (e0 && counter_clear_select[1:0] == 2'h1 |=> channel_counter == 16'h0000)
    else $error("no clear");
  a_match_flag: assert property (e0 |=> match_flag[0] && irq_req)
    else $error("match flag");
  a_ovf_flag: assert property (t && fr && channel_counter == 16'hFFFF |=> ovf_flag && irq_req)
    else $error("overflow flag");
  cover property (go);
  cover property (e0 && !stop_mode_select);
  cover property (t && fr && channel_counter == 16'hFFFF);
endmodule

// ---- sim/tocc_pins.sv ----
// pin side model: reads the compare pins, drives released pins
`timescale 1ns/1ps
module tocc_pins (
  input wire logic mclk,
  input wire logic [3:0] oe,
  input wire logic [3:0] dout,
  input wire logic [3:0] drv,
  input wire logic [3:0] lvl,
  output logic [3:0] pin
);
  logic [3:0] pat = 4'h5;
  // a floating pin wanders so a stale level cannot pass as valid
  always @(posedge mclk) pat <= ~pat;
  assign pin = (oe & dout) | (~oe & drv & lvl) | (~oe & ~drv & pat);
endmodule

// ---- sim/tocc_channel_tb.sv ----
// self-checking bench for the output compare channel
`timescale 1ns/1ps
module tocc_channel_tb;
  logic mclk = 0, sys_rst = 1, fosc = 0, ext = 0, wr = 0, rb = 0, sms = 1, oc = 0, b;
  logic [2:0] src = 0, ccs = 0;
  logic [1:0] edg = 0, fd = 0;
  logic [3:0] ce = 0, il = 0, mc = 0, drv = 4'h5, lvl = 0, pin, cp, oe, fi, mf;
  logic [7:0] act = 0;
  logic [5:0] fcfg = 0;
  logic [15:0] m0 = 16'hFFFF, m1 = 16'hFFFF, cnt, c0;
  logic run, ovf, irq;
  int error_cnt = 0, comparisons = 0, i, j, n, k;
  tocc_channel uut (.mclk(mclk), .sys_rst(sys_rst), .fast_oscillator_clock(fosc),
    .external_count_input(ext), .pin_in(pin), .count_run_wr(wr), .count_run_bit(rb),
    .stop_mode_select(sms), .source_select(src), .edge_select(edg),
    .counter_clear_select(ccs), .compare_enable(ce), .match_action(act),
    .initial_level(il), .filter_config_reg(fcfg), .match_value_reg0(m0),
    .match_value_reg1(m1), .match_value_reg2(16'h0008), .match_value_reg3(16'h0010),
    .match_clear(mc), .ovf_clear(oc), .channel_counter(cnt), .counter_running(run),
    .compare_pin(cp), .compare_pin_oe(oe), .filtered_in(fi), .match_flag(mf),
    .ovf_flag(ovf), .irq_req(irq));
  tocc_pins pm (.mclk(mclk), .oe(oe), .dout(cp), .drv(drv), .lvl(lvl), .pin(pin));
  initial forever #2.5 mclk = ~mclk;
  // fast oscillator at one eighth of mclk
  always @(posedge mclk) begin
    fd <= fd + 2'h1;
    if (fd == 2'h3) fosc <= ~fosc;
  end
  function int div(input logic [2:0] s);
    return s == 3'h6 ? 8 : s == 3'h4 ? 32 : 1 << s;
  endfunction
  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task test_done;
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wrb(input logic v);
    @(posedge mclk);
    wr <= 1;
    rb <= v;
    @(posedge mclk);
    wr <= 0;
    @(negedge mclk);
  endtask
  task pulse(input int p, input int w, input logic e);
    logic s;
    s = 0;
    for (int c = 0; c < w + 8; c++) begin
      @(posedge mclk);
      lvl[p] <= c < w;
      @(negedge mclk);
      s = s | fi[p];
    end
    chk(s, e);
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    test_done;
  end
  // ----
  // tests
  // ----
  initial begin
    void'($urandom(1981));
    repeat (20) @(posedge mclk);
    sys_rst <= 0;
    fcfg <= 6'h11;
    pulse(0, 7, 0);
    pulse(0, 24, 1);
    @(posedge mclk);
    fcfg <= 6'h01;
    repeat (8) @(negedge mclk);
    pulse(0, 2, 0);
    pulse(0, 3, 1);
    pulse(2, 3, 1);
    wrb(1);
    for (j = 0; j < 6; j++) begin
      @(posedge mclk);
      src <= j == 5 ? 3'h6 : 3'(j);
      repeat (40) @(negedge mclk);
      c0 = cnt;
      repeat (320) @(negedge mclk);
      chk(cnt - c0, 16'(320 / div(src)));
    end
    @(posedge mclk);
    src <= 3'h5;
    for (j = 0; j < 3; j++) begin
      @(posedge mclk);
      edg <= 2'(j);
      repeat (8) @(negedge mclk);
      c0 = cnt;
      repeat (5) begin
        repeat (4) @(posedge mclk);
        ext <= 1;
        repeat (4) @(posedge mclk);
        ext <= 0;
      end
      repeat (8) @(negedge mclk);
      chk(cnt - c0, j == 2 ? 16'hA : 16'h5);
    end
    @(posedge mclk);
    src <= 3'h0;
    for (i = 0; i < 70000 && ovf !== 1'b1; i++) @(negedge mclk);
    chk(cnt, 16'h0000);
    chk(irq, 1);
    wrb(0);
    @(posedge mclk);
    oc <= 1;
    @(posedge mclk);
    oc <= 0;
    @(negedge mclk);
    chk(ovf, 0);
    @(posedge mclk);
    ce <= 4'h3;
    act <= 8'h0F;
    for (j = 0; j < 6; j++) begin
      k = j % 2;
      n = 10 * j + 10 + $urandom_range(9, 0);
      @(posedge mclk);
      ccs <= k ? 3'h2 : 3'h1;
      m0 <= k ? 16'hFFFF : n[15:0];
      m1 <= k ? n[15:0] : 16'hFFFF;
      il <= 4'($urandom);
      wrb(1);
      b = cp[k];
      for (i = 0; i < 99 && cp[k] === b; i++) @(negedge mclk);
      b = cp[k];
      for (i = 0; i < 99 && cp[k] === b; i++) @(negedge mclk);
      chk(16'(i), 16'(n + 1));
      wrb(0);
    end
    chk(oe, 4'h3);
    @(posedge mclk);
    sms <= 0;
    m0 <= 16'h0064;
    m1 <= 16'h0050;
    ccs <= 3'h1;
    act <= 8'h0B;
    il <= 4'h0;
    wrb(1);
    wrb(0);
    chk(run, 1);
    for (i = 0; i < 200 && run !== 1'b0; i++) @(negedge mclk);
    repeat (9) @(negedge mclk);
    chk(cnt, 16'h0000);
    chk(cp[1:0], 2'h3);
    chk(mf[0], 1);
    test_done;
  end
endmodule
bind tocc_channel tocc_chk chk_i (.*);
